//--- verilog/uuf_defs.svh
// Purpose: constants of the usb uart fifo core
// Assumes: 25 MHz core clock
// Notes: pin map is bit index into pin_* buses
//
// Behaviour
// - reset to 9600 8N1, no flow control
// - 1024-byte tx buffer, commit on good crc
// - load shifter only when idle or waiting for the high byte
// - start, data lsb first, parity, stop
// - formats 7/8 any parity, 9 without parity
// - ninth tx bit zero outside wide mode
// - wide nine-bit tx takes two bytes
// - received characters into 1024-byte rx buffer
// - normal 7/8-bit rx stores data only
// - normal 9-bit rx stores low eight bits
// - wide rx adds status byte per character
// - wide 9-bit status carries ninth bit
// - 7-bit bit7 zero, 9-bit parity flag zero
// - error flags sticky until err_clear
// - full packet acknowledged when buffered
// - short packet after three character times
// - low latency returns any buffered data
// - slow baud request forces low latency
// - rx never general purpose; tx becomes an undriven input when its edge_sel bit is set
// - flow pins only when both fields 001
// - request output drops near buffer full
// - clear input checked only before each character
`ifndef UUF_DEFS_SVH
`define UUF_DEFS_SVH
`define UUF_CLK_HZ 25000000
`define UUF_RST_BAUD 9600
`define UUF_MAX_BAUD 1562500
`define UUF_RST_BITS 4'h8
`define UUF_LLAT_BAUD 46921
`define UUF_HS_PKT 512
`define UUF_FS_PKT 64
`define UUF_TMO_TICKS 48
`define UUF_RTS_OFF 960
`define UUF_RTS_ON 768
`define UUF_FC_HW 3'h1
`define UUF_PM_RTS 3'h1
`define UUF_ST_PAR 0
`define UUF_ST_BRK 1
`define UUF_ST_FRM 2
`define UUF_ST_OVR 3
`define UUF_PIN_TX 0
`define UUF_PIN_RX 1
`define UUF_PIN_CLR 4
`define UUF_PIN_REQ 5
`endif

//--- verilog/uuf_pkg.sv
// Purpose: types of the usb uart fifo core
// Assumes: nothing
// Notes: gray codes along the usual frame path
package uuf_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
		TX_PAR = 3'h2, TX_STOP = 3'h6, TX_HI = 3'h4
	} uuf_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
		RX_PAR = 3'h2, RX_STOP = 3'h6, RX_STAT = 3'h4
	} uuf_rx_st_t;
endpackage

//--- verilog/uuf_fifo.sv
// Purpose: byte fifo with staged writes
// Assumes: one clock, synchronous reset
// Notes: reads see only committed words
`timescale 1ns/1ps
module uuf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 1024,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	input wire logic commit,
	input wire logic drop,
	input wire logic rd_en,
	output logic [W-1:0] rd_data,
	output logic [AW:0] count,
	output logic [AW:0] free
);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp_q, cp_q, rp_q;
	logic [AW:0] used;
	logic do_wr;

	if ((DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two");
	end

	assign used = wp_q - rp_q;
	assign do_wr = wr_en && used != (AW+1)'(DEPTH);
	assign rd_data = mem[rp_q[AW-1:0]];
	assign count = cp_q - rp_q;
	assign free = (AW+1)'(DEPTH) - used;

	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem[wp_q[AW-1:0]] <= wr_data;
		end
	end

	// staged words become visible only on commit; drop rewinds them
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wp_q <= '0;
			cp_q <= '0;
		end else if (drop) begin
			wp_q <= cp_q;
		end else begin
			wp_q <= wp_q + (AW+1)'(do_wr);
			if (commit) begin
				cp_q <= wp_q + (AW+1)'(do_wr);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rp_q <= '0;
		end else if (rd_en && count != '0) begin
			rp_q <= rp_q + 1'b1;
		end
	end
endmodule

//--- verilog/uuf_core.sv
// Purpose: usb-fed uart with tx/rx buffers and bulk-in rules
// Assumes: bulk-out bytes and bulk-in requests from the usb engine
// Notes: 16x oversampled receiver, fractional baud accumulator
`timescale 1ns/1ps
`include "uuf_defs.svh"
module uuf_core #(
	parameter int FIFO_DEPTH = 1024,
	parameter int CW = $clog2(FIFO_DEPTH) + 1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] out_data,
	input wire logic out_valid,
	input wire logic out_crc_good,
	input wire logic out_crc_bad,
	output logic [CW-1:0] out_free_q,
	input wire logic in_req,
	input wire logic in_hs,
	output logic in_ack_q,
	output logic in_nak_q,
	output logic [7:0] in_data_q,
	output logic in_valid_q,
	output logic in_last_q,
	input wire logic lc_valid,
	input wire logic [23:0] lc_baud,
	input wire logic [3:0] lc_bits,
	input wire logic lc_par_en,
	input wire logic lc_par_odd,
	input wire logic lc_stop2,
	input wire logic low_lat_bit,
	input wire logic tx_wide,
	input wire logic rx_wide,
	input wire logic [2:0] pin_mode,
	input wire logic [2:0] flow_ctrl,
	input wire logic [7:0] gpio_sel,
	input wire logic [7:0] gpio_dout,
	input wire logic [7:0] gpio_dir,
	input wire logic [7:0] edge_sel,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out_q,
	output logic [7:0] pin_oe_q,
	output logic [7:0] gpio_rd_q,
	input wire logic err_clear,
	output logic [3:0] err_status_q,
	output logic low_lat_q
);
	import uuf_pkg::*;

	if (FIFO_DEPTH < 1024) begin : g_chk
		$error("buffers must hold at least one packet and the request threshold");
	end

	function automatic logic par_fn(input logic [8:0] d, input logic [3:0] n,
			input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction

	logic [7:0] pin_s1_q, pin_s2_q;
	logic [23:0] baud_q;
	logic [3:0] bits_q;
	logic par_q, odd_q, stop2_q, llat_auto_q;
	logic [25:0] acc_q;
	logic [27:0] acc_sum;
	logic tick;
	logic fc_on, clr_n, rx_pin;
	logic [CW-1:0] tx_cnt, tx_free, rx_cnt, rx_free;
	logic [7:0] tx_rd_data, rx_rd_data;
	logic tx_rd, rx_wr;
	logic [7:0] rx_wdata;
	uuf_tx_st_t tx_st_q;
	logic [8:0] tx_sh_q;
	logic [3:0] tx_cnt_q, tx_sub_q;
	logic tx_line_q;
	uuf_rx_st_t rx_st_q;
	logic [8:0] rx_sh_q, rx_al;
	logic [3:0] rx_cnt_q, rx_sub_q;
	logic rx_pbit_q, ovr_pend_q;
	logic [7:0] stat_q, stat_d;
	logic rx_done, rx_space, ev_pe, ev_brk, ev_fe;
	logic [3:0] err_ev;
	logic [15:0] idle_q;
	logic [15:0] tmo_lim;
	logic tmo;
	logic [CW-1:0] in_left_q, pkt;
	logic rts_n_q;

	// pins are asynchronous to the core
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pin_s1_q <= 8'hff;
			pin_s2_q <= 8'hff;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign rx_pin = pin_s2_q[`UUF_PIN_RX];
	assign clr_n = pin_s2_q[`UUF_PIN_CLR];
	assign fc_on = pin_mode == `UUF_PM_RTS && flow_ctrl == `UUF_FC_HW;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			baud_q <= 24'(`UUF_RST_BAUD);
			bits_q <= `UUF_RST_BITS;
			par_q <= 1'b0;
			odd_q <= 1'b0;
			stop2_q <= 1'b0;
			llat_auto_q <= 1'b0;
		end else if (lc_valid) begin
			// faster rates clamp: accumulator gives at most one tick per clock
			baud_q <= (lc_baud > 24'(`UUF_MAX_BAUD)) ? 24'(`UUF_MAX_BAUD) : lc_baud;
			bits_q <= (lc_bits == 4'h7 || lc_bits == 4'h9) ? lc_bits : `UUF_RST_BITS;
			par_q <= lc_par_en && lc_bits != 4'h9;
			odd_q <= lc_par_odd;
			stop2_q <= lc_stop2;
			llat_auto_q <= lc_baud < 24'(`UUF_LLAT_BAUD);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			low_lat_q <= 1'b0;
		end else begin
			low_lat_q <= low_lat_bit || llat_auto_q;
		end
	end

	// 16x tick, fractional so any rate lands without a divider
	assign acc_sum = {2'h0, acc_q} + {baud_q, 4'h0};
	assign tick = acc_sum >= 28'(`UUF_CLK_HZ);
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			acc_q <= '0;
		end else if (tick) begin
			acc_q <= 26'(acc_sum - 28'(`UUF_CLK_HZ));
		end else begin
			acc_q <= acc_sum[25:0];
		end
	end

	uuf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wr_en(out_valid),
		.wr_data(out_data),
		.commit(out_crc_good),
		.drop(out_crc_bad),
		.rd_en(tx_rd),
		.rd_data(tx_rd_data),
		.count(tx_cnt),
		.free(tx_free)
	);

	uuf_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rxf (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wr_en(rx_wr),
		.wr_data(rx_wdata),
		.commit(1'b1),
		.drop(1'b0),
		.rd_en(in_left_q != '0),
		.rd_data(rx_rd_data),
		.count(rx_cnt),
		.free(rx_free)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			out_free_q <= CW'(FIFO_DEPTH);
		end else begin
			out_free_q <= tx_free;
		end
	end

	// load from idle (clear present only when flow control is on), or the high byte in TX_HI
	assign tx_rd = tx_cnt != '0 && ((tx_st_q == TX_IDLE && (!fc_on || !clr_n))
		|| tx_st_q == TX_HI);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= '0;
			tx_cnt_q <= '0;
			tx_sub_q <= '0;
			tx_line_q <= 1'b1;
		end else begin
			unique case (tx_st_q)
				TX_IDLE: begin
					tx_line_q <= 1'b1;
					tx_sub_q <= '0;
					if (tx_rd) begin
						tx_sh_q <= {1'b0, tx_rd_data};
						// wide nine waits for high byte
						tx_st_q <= (bits_q == 4'h9 && tx_wide) ? TX_HI : TX_START;
					end
				end
				TX_HI: begin
					if (tx_rd) begin
						tx_sh_q[8] <= tx_rd_data[0];
						tx_st_q <= TX_START;
					end
				end
				default: begin
					// start edge waits for a tick, so the start bit spans 16 full ticks
					if (tx_st_q == TX_START && tx_line_q) begin
						if (tick) begin
							tx_line_q <= 1'b0;
						end
					end else if (tick) begin
						tx_sub_q <= tx_sub_q + 4'h1;
					end
					if (tick && tx_sub_q == 4'hf) begin
						if (tx_st_q == TX_START) begin
							tx_line_q <= tx_sh_q[0];
							tx_cnt_q <= 4'h1;
							tx_st_q <= TX_DATA;
						end else if (tx_st_q == TX_DATA && tx_cnt_q != bits_q) begin
							tx_line_q <= tx_sh_q[tx_cnt_q];
							tx_cnt_q <= tx_cnt_q + 4'h1;
						end else if (tx_st_q == TX_DATA && par_q) begin
							tx_line_q <= par_fn(tx_sh_q, bits_q, odd_q);
							tx_st_q <= TX_PAR;
						end else if (tx_st_q != TX_STOP) begin
							tx_line_q <= 1'b1;
							tx_cnt_q <= '0;
							tx_st_q <= TX_STOP;
						end else if (stop2_q && tx_cnt_q == '0) begin
							tx_cnt_q <= 4'h1;
						end else begin
							tx_st_q <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// receiver: sample mid-bit at sub count 15 after a half-bit start check
	assign rx_done = rx_st_q == RX_STOP && tick && rx_sub_q == 4'hf;
	assign rx_al = rx_sh_q >> (4'h9 - bits_q);
	assign rx_space = rx_free >= (rx_wide ? CW'(2) : CW'(1));
	assign ev_fe = rx_done && !rx_pin;
	assign ev_brk = ev_fe && rx_al == '0 && !(par_q && rx_pbit_q);
	// parity flag only with parity on
	assign ev_pe = rx_done && par_q && par_fn(rx_al, bits_q, odd_q) != rx_pbit_q;
	assign err_ev = {rx_done && !rx_space, ev_fe, ev_brk, ev_pe};

	always_comb begin
		stat_d = '0;
		stat_d[`UUF_ST_BRK] = ev_brk;
		stat_d[`UUF_ST_FRM] = ev_fe;
		stat_d[`UUF_ST_OVR] = ovr_pend_q;
		// ninth bit in status bit 0
		stat_d[`UUF_ST_PAR] = (bits_q == 4'h9) ? rx_al[8] : ev_pe;
	end

	always_comb begin
		rx_wr = 1'b0;
		rx_wdata = rx_al[7:0];
		if (rx_st_q == RX_STAT) begin
			rx_wr = 1'b1;
			rx_wdata = stat_q;
		end else if (rx_done && rx_space) begin
			rx_wr = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rx_st_q <= RX_IDLE;
			rx_sh_q <= '0;
			rx_cnt_q <= '0;
			rx_sub_q <= '0;
			rx_pbit_q <= 1'b0;
			stat_q <= '0;
		end else begin
			if (tick) begin
				rx_sub_q <= rx_sub_q + 4'h1;
			end
			unique case (rx_st_q)
				RX_IDLE: begin
					if (tick && !rx_pin) begin
						rx_sub_q <= '0;
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					// glitch filter: line must still be low at mid start bit
					if (tick && rx_sub_q == 4'h7) begin
						rx_sub_q <= '0;
						rx_cnt_q <= '0;
						rx_st_q <= rx_pin ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (tick && rx_sub_q == 4'hf) begin
						rx_sh_q <= {rx_pin, rx_sh_q[8:1]};
						rx_cnt_q <= rx_cnt_q + 4'h1;
						if (rx_cnt_q + 4'h1 == bits_q) begin
							rx_st_q <= par_q ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (tick && rx_sub_q == 4'hf) begin
						rx_pbit_q <= rx_pin;
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_done) begin
						stat_q <= stat_d;
						rx_st_q <= (rx_wide && rx_space) ? RX_STAT : RX_IDLE;
					end
				end
				RX_STAT: begin
					rx_st_q <= RX_IDLE;
				end
				default: begin
					rx_st_q <= RX_IDLE;
				end
			endcase
		end
	end

	// dropped character marks the next status byte as overrun
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ovr_pend_q <= 1'b0;
		end else if (rx_done) begin
			ovr_pend_q <= !rx_space || (ovr_pend_q && !rx_wide);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			err_status_q <= '0;
		end else begin
			err_status_q <= (err_clear ? 4'h0 : err_status_q) | err_ev;
		end
	end

	// character-time idle counter in 16x ticks
	assign tmo_lim = 16'(`UUF_TMO_TICKS) * 16'(4'h2 + bits_q + 4'(par_q) + 4'(stop2_q));
	assign tmo = idle_q > tmo_lim;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			idle_q <= '0;
		end else if (rx_wr) begin
			idle_q <= '0;
		end else if (tick && idle_q != 16'hffff) begin
			idle_q <= idle_q + 16'h1;
		end
	end

	assign pkt = in_hs ? CW'(`UUF_HS_PKT) : CW'(`UUF_FS_PKT);
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			in_left_q <= '0;
			in_ack_q <= 1'b0;
			in_nak_q <= 1'b0;
			in_valid_q <= 1'b0;
			in_last_q <= 1'b0;
			in_data_q <= '0;
		end else begin
			in_ack_q <= 1'b0;
			in_nak_q <= 1'b0;
			in_valid_q <= in_left_q != '0;
			in_last_q <= in_left_q == CW'(1);
			in_data_q <= rx_rd_data;
			if (in_left_q != '0) begin
				in_left_q <= in_left_q - CW'(1);
			end else if (in_req && rx_cnt >= pkt) begin
				in_ack_q <= 1'b1;
				in_left_q <= pkt;
			end else if (in_req && rx_cnt != '0 && (low_lat_q || tmo)) begin
				in_ack_q <= 1'b1;
				in_left_q <= rx_cnt;
			end else if (in_req) begin
				in_nak_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rts_n_q <= 1'b0;
		end else if (rx_cnt >= CW'(`UUF_RTS_OFF)) begin
			rts_n_q <= 1'b1;
		end else if (rx_cnt <= CW'(`UUF_RTS_ON)) begin
			rts_n_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pin_out_q <= 8'h01;
			pin_oe_q <= 8'h01;
			gpio_rd_q <= '0;
		end else begin
			gpio_rd_q <= pin_s2_q;
			for (int i = 0; i < 8; i++) begin
				if (edge_sel[i] || i == `UUF_PIN_RX
						|| (fc_on && i == `UUF_PIN_CLR)) begin
					pin_out_q[i] <= 1'b0;
					pin_oe_q[i] <= 1'b0;
				end else if (i == `UUF_PIN_TX) begin
					pin_out_q[i] <= tx_line_q;
					pin_oe_q[i] <= 1'b1;
				end else if (fc_on && i == `UUF_PIN_REQ) begin
					pin_out_q[i] <= rts_n_q;
					pin_oe_q[i] <= 1'b1;
				end else begin
					pin_out_q[i] <= gpio_dout[i];
					pin_oe_q[i] <= gpio_sel[i] && gpio_dir[i];
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	chk_clear_holds_tx: assert property (
		tx_st_q == TX_IDLE && fc_on && clr_n |=> tx_st_q == TX_IDLE)
		else $error("transmitter started while clear withdrawn");
	chk_ninth_zero: assert property (
		tx_st_q == TX_START && bits_q == 4'h9 && !tx_wide |-> !tx_sh_q[8])
		else $error("ninth tx bit not zero");
	chk_full_ack: assert property (
		in_req && in_left_q == '0 && rx_cnt >= pkt |=> in_ack_q ##1 in_valid_q)
		else $error("full packet not acknowledged");
	chk_short_nak: assert property (
		in_req && in_left_q == '0 && rx_cnt < pkt && !low_lat_q && !tmo |=> in_nak_q)
		else $error("short packet not refused");
	chk_lowlat_ack: assert property (
		in_req && in_left_q == '0 && rx_cnt != '0 && low_lat_q |=> in_ack_q && !in_nak_q)
		else $error("low latency data not returned");
	chk_auto_lowlat: assert property (
		lc_valid && lc_baud < 24'(`UUF_LLAT_BAUD) |=> llat_auto_q ##1 low_lat_q)
		else $error("slow rate did not force low latency");
	chk_request_drop: assert property (
		rx_cnt >= CW'(`UUF_RTS_OFF) |=> rts_n_q)
		else $error("request output kept high fill");
	chk_err_sticky: assert property (
		err_status_q[`UUF_ST_FRM] && !err_clear |=> err_status_q[`UUF_ST_FRM])
		else $error("error flag lost without clear");
	chk_status_byte: assert property (
		rx_st_q == RX_STAT |-> rx_wr && rx_wdata[7:4] == 4'h0)
		else $error("bad status byte");
	chk_rx_pin_input: assert property (
		!pin_oe_q[`UUF_PIN_RX])
		else $error("rx pin driven");
	chk_flow_pin: assert property (
		fc_on && !edge_sel[`UUF_PIN_REQ] |=> pin_oe_q[`UUF_PIN_REQ]
		&& pin_out_q[`UUF_PIN_REQ] == $past(rts_n_q))
		else $error("request pin not driven by flow control");
endmodule

//--- sim/uuf_remote.sv
// Purpose: remote uart on the far end of the serial line
// Assumes: 16 core cycles per bit once the core runs at full rate
// Notes: captured frames hold the bits after start, lsb first
`timescale 1ns/1ps
module uuf_remote (
	input wire logic core_clk,
	input wire logic tx_line,
	input wire logic req_n,
	input wire logic hold,
	input wire logic [3:0] nbits,
	output logic rx_line,
	output logic clr_n
);
	logic [11:0] cap_q[$];
	logic [11:0] w;
	// accept gate
	// clear stays asserted (low) unless the bench stalls us
	assign clr_n = hold;
	initial begin
		rx_line = 1'b1;
		forever begin
			@(negedge tx_line);
			repeat (8) @(posedge core_clk);
			w = 12'h000;
			for (int i = 0; i < nbits; i++) begin
				repeat (16) @(posedge core_clk);
				w[i] = tx_line;
			end
			cap_q.push_back(w);
		end
	end
	task automatic send(input logic [11:0] f, input int n);
		// hold off while the core withdraws its request
		while (req_n !== 1'b0)
			@(posedge core_clk);
		@(posedge core_clk);
		rx_line <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (16) @(posedge core_clk);
			rx_line <= f[i];
		end
		repeat (16) @(posedge core_clk);
	endtask
endmodule

//--- sim/usb_uart_fifo_core_tb.sv
// Purpose: self-checking bench of the usb uart fifo core
// Assumes: 1562500 bps after setup, so one bit is 16 cycles
// Notes: random data from a 32-bit lfsr with fixed start
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module usb_uart_fifo_core_tb;
	localparam int FAST = 1562500;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] out_data = 8'h00;
	logic out_valid = 1'b0, out_crc_good = 1'b0, out_crc_bad = 1'b0;
	logic in_req = 1'b0, in_hs = 1'b0, lc_valid = 1'b0, hold = 1'b0;
	logic [23:0] lc_baud = 24'h00_0000;
	logic [3:0] lc_bits = 4'h8, nb = 4'ha;
	logic [2:0] lc_fmt = 3'h0, pin_mode = 3'h0, flow_ctrl = 3'h0;
	logic low_lat_bit = 1'b0, tx_wide = 1'b0, rx_wide = 1'b0, err_clear = 1'b0;
	logic [7:0] gpio_sel = 8'h00, gpio_dir = 8'h00, gpio_dout = 8'h00, edge_sel = 8'h00;
	logic [31:0] seed = 32'h0000_b702;
	int n_errors = 0, compares = 0, cb = 8;
	logic cpe = 1'b0;
	logic [10:0] out_free_q;
	logic in_ack_q, in_nak_q, in_valid_q, in_last_q, low_lat_q, rx_line, clr_n, req_n;
	logic [7:0] in_data_q, pin_out_q, pin_oe_q, gpio_rd_q, pin_in;
	logic [3:0] err_status_q;
	assign pin_in = {3'h7, clr_n, 2'h3, rx_line, 1'b1};
	// an undriven request pin reads as go
	assign req_n = pin_oe_q[5] ? pin_out_q[5] : 1'b0;
	always #20 core_clk = ~core_clk;
	uuf_core dut_u (.core_clk, .rst_b, .out_data, .out_valid, .out_crc_good, .out_crc_bad,
		.out_free_q, .in_req, .in_hs, .in_ack_q, .in_nak_q, .in_data_q, .in_valid_q,
		.in_last_q, .lc_valid, .lc_baud, .lc_bits, .lc_par_en(lc_fmt[2]),
		.lc_par_odd(lc_fmt[1]), .lc_stop2(lc_fmt[0]), .low_lat_bit, .tx_wide, .rx_wide,
		.pin_mode, .flow_ctrl, .gpio_sel, .gpio_dout, .gpio_dir, .edge_sel,
		.pin_in, .pin_out_q, .pin_oe_q, .gpio_rd_q, .err_clear, .err_status_q, .low_lat_q);
	uuf_remote rem_u (.core_clk, .tx_line(pin_out_q[0]), .req_n, .hold, .nbits(nb),
		.rx_line, .clr_n);
	function automatic logic [8:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[8:0];
	endfunction
	function automatic logic [11:0] frame(input logic [8:0] d, input logic odd);
		logic [11:0] w;
		logic p;
		w = 12'hfff;
		p = odd;
		for (int i = 0; i < cb; i++) begin
			w[i] = d[i];
			p = p ^ d[i];
		end
		if (cpe)
			w[cb] = p;
		return w & ((12'h001 << nb) - 12'h001);
	endfunction
	task automatic set_fmt(input int baud, input int b, input logic [2:0] f);
		@(posedge core_clk);
		lc_baud <= 24'(baud);
		lc_bits <= 4'(b);
		lc_fmt <= f;
		lc_valid <= 1'b1;
		cb = b;
		// nine-bit characters never carry parity
		cpe = f[2] && b != 9;
		nb <= 4'(b + (cpe ? 2 : 1) + (f[0] ? 1 : 0));
		@(posedge core_clk);
		lc_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic push(input logic [7:0] d[$], input logic good);
		foreach (d[i]) begin
			@(posedge core_clk);
			out_valid <= 1'b1;
			out_data <= d[i];
		end
		@(posedge core_clk);
		out_valid <= 1'b0;
		out_crc_good <= good;
		out_crc_bad <= !good;
		@(posedge core_clk);
		out_crc_good <= 1'b0;
		out_crc_bad <= 1'b0;
	endtask
	task automatic exp_tx(input logic [11:0] e);
		for (int k = 0; k < 600 && rem_u.cap_q.size() == 0; k++)
			@(posedge core_clk);
		`CHK("tx_frame", e, rem_u.cap_q.pop_front())
	endtask
	task automatic pull(output logic [1:0] r, output logic [7:0] q[$]);
		int k;
		q = {};
		@(posedge core_clk);
		in_req <= 1'b1;
		@(posedge core_clk);
		in_req <= 1'b0;
		r = 2'b00;
		for (k = 0; k < 4 && r == 2'b00; k++) begin
			#1;
			r = {in_ack_q === 1'b1, in_nak_q === 1'b1};
			if (r == 2'b00)
				@(posedge core_clk);
		end
		for (k = 0; k < 1100 && r[1]; k++) begin
			@(posedge core_clk);
			#1;
			if (in_valid_q === 1'b1)
				q.push_back(in_data_q);
			if (in_last_q === 1'b1)
				break;
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge core_clk);
		n_errors++;
		$display("[ERR] watchdog expired");
		wrap_up();
	end
	initial begin
		logic [7:0] q[$];
		logic [7:0] sq[$];
		logic [1:0] r;
		logic [8:0] d;
		logic [11:0] w;
		logic [7:0] c;
		int n;
		logic [7:0] txt [6] = '{8'h70, 8'h7c, 8'h8a, 8'h82, 8'h98, 8'h93};
		logic [7:0] rxt [6] = '{8'h80, 8'h90, 8'h87, 8'h72, 8'h92, 8'h75};
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK("pin_out", 8'h01, pin_out_q)
		`CHK("pin_oe", 8'h01, pin_oe_q)
		`CHK("free", 11'h400, out_free_q)
		`CHK("flags", 5'h00, {low_lat_q, err_status_q})
		push('{8'hff}, 1'b1);
		n = 0;
		for (int k = 0; k < 200 && pin_out_q[0] !== 1'b0; k++)
			@(posedge core_clk);
		while (pin_out_q[0] === 1'b0 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		`CHK("bit_len", 1'b1, n >= 2600 && n <= 2610)
		repeat (26100) @(posedge core_clk);
		rem_u.cap_q.delete();
		set_fmt(9600, 8, 3'h0);
		`CHK("auto_low_lat", 1'b1, low_lat_q)
		set_fmt(FAST, 8, 3'h0);
		`CHK("low_lat_off", 1'b0, low_lat_q)
		gpio_sel <= 8'hff;
		gpio_dir <= 8'hff;
		gpio_dout <= 8'h5a;
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("data_pins", 16'hfd59, {pin_oe_q, pin_out_q})
		`CHK("gpio_rd", 8'hef, gpio_rd_q)
		@(posedge core_clk);
		edge_sel <= 8'h08;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("edge_pin", 16'hf551, {pin_oe_q, pin_out_q})
		@(posedge core_clk);
		edge_sel <= 8'h00;
		gpio_dout <= 8'h00;
		gpio_sel <= 8'h00;
		gpio_dir <= 8'h00;
		foreach (txt[i]) begin
			c = txt[i];
			set_fmt(FAST, int'(c[7:4]), c[3:1]);
			tx_wide <= c[0];
			d = rnd();
			if (c[0])
				push('{d[7:0], {~d[7:1], d[8]}}, 1'b1);
			else
				push('{d[7:0]}, 1'b1);
			exp_tx(frame(c[0] ? d : {1'b0, d[7:0]}, c[2]));
		end
		push('{8'h5a, 8'ha5}, 1'b0);
		repeat (300) @(posedge core_clk);
		#1;
		`CHK("dropped", 32'h0, 32'(rem_u.cap_q.size()))
		`CHK("free_drop", 11'h400, out_free_q)
		set_fmt(FAST, 8, 3'h0);
		tx_wide <= 1'b0;
		pin_mode <= 3'h1;
		flow_ctrl <= 3'h1;
		hold <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("flow_pins", 3'b100, {pin_oe_q[5:4], pin_out_q[5]})
		d = rnd();
		c = 8'(rnd());
		push('{d[7:0], c}, 1'b1);
		repeat (300) @(posedge core_clk);
		`CHK("paused", 32'h0, 32'(rem_u.cap_q.size()))
		hold <= 1'b0;
		for (int k = 0; k < 100 && pin_out_q[0] !== 1'b0; k++)
			@(posedge core_clk);
		hold <= 1'b1;
		repeat (400) @(posedge core_clk);
		`CHK("one_char", 32'h1, 32'(rem_u.cap_q.size()))
		exp_tx(frame({1'b0, d[7:0]}, 1'b0));
		hold <= 1'b0;
		exp_tx(frame({1'b0, c}, 1'b0));
		@(posedge core_clk);
		pin_mode <= 3'h0;
		flow_ctrl <= 3'h0;
		low_lat_bit <= 1'b1;
		foreach (rxt[i]) begin
			c = rxt[i];
			set_fmt(FAST, int'(c[7:4]), {c[2], 2'b00});
			rx_wide <= c[1];
			d = rnd();
			w = frame(d, 1'b0);
			w[cb] = w[cb] ^ c[0];
			rem_u.send(w, int'(nb));
			repeat (40) @(posedge core_clk);
			pull(r, q);
			`CHK("rx_len", {2'b10, c[1] ? 8'h02 : 8'h01}, {r, 8'(q.size())})
			`CHK("rx_data", cb == 7 ? {1'b0, d[6:0]} : d[7:0], q[0])
			if (c[1])
				`CHK("rx_stat", {7'h00, cb == 9 ? d[8] : c[0]}, q[1])
		end
		#1;
		`CHK("err_sticky", 4'h1, err_status_q)
		@(posedge core_clk);
		err_clear <= 1'b1;
		@(posedge core_clk);
		err_clear <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("err_cleared", 4'h0, err_status_q)
		@(posedge core_clk);
		low_lat_bit <= 1'b0;
		rx_wide <= 1'b1;
		set_fmt(FAST, 8, 3'h0);
		pull(r, q);
		`CHK("empty_nak", 2'b01, r)
		sq = {};
		repeat (32) begin
			d = rnd();
			sq.push_back(d[7:0]);
			sq.push_back(8'h00);
			rem_u.send(frame(d, 1'b0), int'(nb));
		end
		repeat (30) @(posedge core_clk);
		pull(r, q);
		`CHK("full_pkt", {2'b10, 8'h40}, {r, 8'(q.size())})
		`CHK("pkt_bytes", 1'b1, q == sq)
		rem_u.send(frame(9'h0a5, 1'b0), int'(nb));
		repeat (30) @(posedge core_clk);
		pull(r, q);
		`CHK("short_nak", 2'b01, r)
		repeat (600) @(posedge core_clk);
		pull(r, q);
		`CHK("timeout_pkt", {2'b10, 8'h02, 8'ha5}, {r, 8'(q.size()), q[0]})
		wrap_up();
	end
endmodule
